// *** pkg/adccs_pkg.sv ***
// Shared constants for the calibration sequencer: register map, field
// positions, reset values, mode and filter codes, timing figures.
// Assumes a 100 MHz pclk and a 76.8 kHz converter master clock.
package adccs_pkg;
  // Clock rates and derived master-clock prescale
  localparam int PCLK_HZ = 100_000_000;
  localparam int MCLK_HZ = 76_800;
  localparam int MCLK_DIV_DEF = PCLK_HZ / MCLK_HZ;

  // Register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [1:0] BANK_SETUP = 2'h1;
  localparam logic [1:0] BANK_OFFS = 2'h2;
  localparam logic [1:0] BANK_GAIN = 2'h3;

  // Control register fields
  localparam int CT_CH_LSB = 4;
  localparam int CT_RANGE = 8;
  // Status register fields
  localparam int ST_NRDY = 0;
  localparam int ST_REF = 1;
  localparam int ST_BUSY = 2;
  // Setup register fields
  localparam int SF_FM_LSB = 0;
  localparam int SF_FS_LSB = 4;
  localparam int SF_GAIN_LSB = 16;
  localparam int SF_BYP = 19;
  localparam int SETUP_W = 20;

  // Converter-mode calibration codes
  localparam logic [3:0] M_IDLE = 4'h0;
  localparam logic [3:0] M_IOFF = 4'h5;
  localparam logic [3:0] M_IGAIN = 4'h6;
  localparam logic [3:0] M_SOFF = 4'h7;
  localparam logic [3:0] M_SGAIN = 4'h8;

  // Filter-mode codes
  localparam logic [3:0] F_SINC4 = 4'h0;
  localparam logic [3:0] F_SINC4_AVG = 4'h1;
  localparam logic [3:0] F_SINC3 = 4'h2;
  localparam logic [3:0] F_REJ60 = 4'h3;
  localparam logic [3:0] F_SINC3_AVG = 4'h4;
  localparam logic [3:0] F_POST1 = 4'h5;
  localparam logic [3:0] F_POST2 = 4'h6;
  localparam logic [3:0] F_POST3 = 4'h7;
  localparam logic [3:0] F_POST4 = 4'h8;

  // First-conversion length in master-clock cycles (per rate step or fixed)
  localparam int FC_SINC4 = 128;
  localparam int FC_SINC4_AVG = 352;
  localparam int FC_SINC3 = 96;
  localparam int FC_SINC3_AVG = 320;
  localparam int FC_POST1 = 2944;
  localparam int FC_POST2 = 3200;
  localparam int FC_POST3 = 3968;
  localparam int FC_POST4 = 4738;
  localparam logic [10:0] FS_SINC4_MAX = 11'h00a;

  // Calibration passes and reset values
  localparam logic [1:0] IGAIN_PASSES = 2'h3;
  localparam logic [2:0] GAIN_CODE_UNITY = 3'h0;
  localparam logic [23:0] OFFS_RST = 24'h800000;
  localparam logic [23:0] GAIN_FACTORY = 24'h555555;
  localparam logic [19:0] SETUP_RST = 20'h00302;

  typedef enum logic [0:0] {CS_IDLE, CS_RUN} adccs_fsm_e;
endpackage

// *** hdl/adccs_sync2.sv ***
// Two-flop synchroniser for one level from outside the pclk domain.
// Assumes the input is a slow pin level.
`timescale 1ns/10ps
module adccs_sync2 import adccs_pkg::*; #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic din,
  output logic dout
);
  typedef struct packed {
    logic s1;
    logic s2;
  } adccs_sync_s;
  adccs_sync_s q;
  adccs_sync_s d;

  // Shift the level through two stages
  always_comb
  begin
    d = q;
    d.s1 = din;
    d.s2 = q.s1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= {RST_VAL, RST_VAL};
    else
      q <= d;
  end

  assign dout = q.s2;
endmodule

// *** hdl/adccs_fconv_timer.sv ***
// Times one first conversion of a filter setup in pclk cycles.
// Assumes start is a one-cycle pulse from logic on pclk.
`timescale 1ns/10ps
module adccs_fconv_timer import adccs_pkg::*; #(
  parameter int MCLK_DIV = MCLK_DIV_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [3:0] filter_mode,
  input wire logic [10:0] rate_sel,
  output logic done
);
  typedef struct packed {
    logic [15:0] pre;
    logic [23:0] ticks;
    logic run;
    logic done;
  } adccs_tmr_s;
  adccs_tmr_s q;
  adccs_tmr_s d;

  if (MCLK_DIV < 1 || MCLK_DIV > 65535)
  begin : g_chk
    $error("MCLK_DIV out of range");
  end

  // Master-clock cycles of one first conversion
  function automatic logic [23:0] first_ticks(input logic [3:0] fm, input logic [10:0] fs);
    logic [10:0] f;
    f = (fs == 11'h000) ? 11'h001 : fs;
    if ((fm == F_SINC4 || fm == F_SINC4_AVG) && f > FS_SINC4_MAX)
      f = FS_SINC4_MAX;
    case (fm)
      F_SINC4: first_ticks = 24'(FC_SINC4 * int'(f));
      F_SINC4_AVG: first_ticks = 24'(FC_SINC4_AVG * int'(f));
      F_SINC3_AVG: first_ticks = 24'(FC_SINC3_AVG * int'(f));
      F_POST1: first_ticks = 24'(FC_POST1);
      F_POST2: first_ticks = 24'(FC_POST2);
      F_POST3: first_ticks = 24'(FC_POST3);
      F_POST4: first_ticks = 24'(FC_POST4);
      default: first_ticks = 24'(FC_SINC3 * int'(f));
    endcase
  endfunction

  // Prescaled countdown of first-conversion length
  always_comb
  begin
    d = q;
    d.done = 1'b0;
    if (start)
    begin
      d.ticks = first_ticks(filter_mode, rate_sel) - 24'h000001;
      d.pre = 16'(MCLK_DIV - 1);
      d.run = 1'b1;
    end
    else if (q.run)
    begin
      if (q.pre == 16'h0000)
      begin
        d.pre = 16'(MCLK_DIV - 1);
        if (q.ticks == 24'h000000)
        begin
          d.run = 1'b0;
          d.done = 1'b1;
        end
        else
          d.ticks = q.ticks - 24'h000001;
      end
      else
        d.pre = q.pre - 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= '0;
    else
      q <= d;
  end

  assign done = q.done;
endmodule

// *** hdl/adccs_top.sv ***
// Calibration sequencer of a sigma-delta converter channel, APB slave.
// Assumes an APB master on pclk, chip select from a pin, and a filter
// datapath that presents the computed coefficient on cal_sample.
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/10ps
// Functional notes
// - Internal gain routes internal full-scale onto amplifier
// - Gain coefficients reset to factory unity values
// - Internal gain refused at unity, amplifier not bypassed
// - Internal gain lasts four first conversions
// - Internal offset shorts positive input to negative
// - Internal offset lasts one first conversion
// - System offset lasts one first conversion
// - System gain lasts one first conversion
// - System span limited to 0.8..2.1 reference/gain; the sequencer does not check the span
// - Setup filter-mode field selects filter type
// - Rate select ignored by post filters
// - Rate select limited per filter type
// - Mode codes 5..8 start the four calibrations
// - Start raises data-ready and not-ready flag
// - Completion commits coefficient, clears flag, idles
module adccs_top import adccs_pkg::*; #(
  parameter int NCH = 8,
  parameter int MCLK_DIV = MCLK_DIV_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cs_n,
  input wire logic [23:0] cal_sample,
  output logic drdy,
  output logic route_fullscale,
  output logic short_pos_neg,
  output logic cal_range_double,
  output logic [3:0] filter_type_sel,
  output logic [3:0] active_chan
);
  typedef struct packed {
    adccs_fsm_e st;
    logic [3:0] mode;
    logic [3:0] ch;
    logic [1:0] pass;
    logic not_ready_flag;
    logic drdy;
    logic refused;
    logic range2;
    logic route_fs;
    logic short_in;
    logic [3:0] filt;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [NCH-1:0][SETUP_W-1:0] setup;
    logic [NCH-1:0][23:0] offs;
    logic [NCH-1:0][23:0] gain;
  } adccs_top_s;

  if (NCH < 1 || NCH > 16)
  begin : g_chk
    $error("NCH must be 1 to 16");
  end

  // Reset image of the whole state
  function automatic adccs_top_s rst_val();
    adccs_top_s r;
    r = '0;
    r.st = CS_IDLE;
    r.drdy = 1'b1;
    r.setup = {NCH{SETUP_RST}};
    r.offs = {NCH{OFFS_RST}};
    r.gain = {NCH{GAIN_FACTORY}};
    r.filt = SETUP_RST[SF_FM_LSB +: 4];
    return r;
  endfunction
  localparam adccs_top_s RST_S = rst_val();

  // Channel-indexed bank hit, in range
  function automatic logic bank_hit(input logic [7:0] a, input logic [1:0] bank);
    return (a[7:6] == bank) && (int'(a[5:2]) < NCH) && (a[1:0] == 2'h0);
  endfunction

  // Calibration code check
  function automatic logic is_cal(input logic [3:0] m);
    return (m == M_IOFF) || (m == M_IGAIN) || (m == M_SOFF) || (m == M_SGAIN);
  endfunction

  adccs_top_s q;
  adccs_top_s d;
  logic cs_low_n;
  logic t_done;
  logic t_start;
  logic acc;
  logic fin;
  logic wr_ctrl;
  logic bad_cfg;
  logic ch_bad;
  logic go;
  logic last;
  logic [3:0] wch;
  logic [3:0] widx;
  logic [1:0] reps;
  logic [SETUP_W-1:0] wsetup;

  adccs_sync2 #(.RST_VAL(1'b1)) u_cs (
    .pclk(pclk),
    .presetn(presetn),
    .din(cs_n),
    .dout(cs_low_n)
  );

  adccs_fconv_timer #(.MCLK_DIV(MCLK_DIV)) u_tmr (
    .pclk(pclk),
    .presetn(presetn),
    .start(t_start),
    .filter_mode(wsetup[SF_FM_LSB +: 4]),
    .rate_sel(wsetup[SF_FS_LSB +: 11]),
    .done(t_done)
  );

  // APB phase and start decode
  assign acc = psel && penable && !q.pready;
  assign fin = psel && penable && q.pready;
  assign widx = paddr[5:2];
  assign wr_ctrl = fin && pwrite && !q.pslverr && (paddr == A_CTRL);
  assign wch = pwdata[CT_CH_LSB +: 4];
  assign ch_bad = int'(wch) >= NCH;
  assign wsetup = (q.st == CS_IDLE) ? q.setup[ch_bad ? 4'h0 : wch] : q.setup[q.ch];
  assign bad_cfg = (pwdata[3:0] == M_IGAIN) && !ch_bad
    && (wsetup[SF_GAIN_LSB +: 3] == GAIN_CODE_UNITY) && !wsetup[SF_BYP];
  assign go = wr_ctrl && (q.st == CS_IDLE) && is_cal(pwdata[3:0]) && !ch_bad && !bad_cfg;
  assign reps = (q.mode == M_IGAIN) ? IGAIN_PASSES : 2'h0;
  assign last = (q.pass == reps);
  assign t_start = go || ((q.st == CS_RUN) && t_done && !last);

  // Next-state logic of sequencer and register file
  always_comb
  begin
    d = q;
    d.pready = acc;
    if (acc)
    begin
      d.prdata = 32'h00000000;
      d.pslverr = 1'b0;
      if (paddr == A_CTRL)
        d.prdata = {23'h000000, q.range2, q.ch, q.mode};
      else if (paddr == A_STAT)
      begin
        d.prdata[ST_NRDY] = q.not_ready_flag;
        d.prdata[ST_REF] = q.refused;
        d.prdata[ST_BUSY] = (q.st == CS_RUN);
      end
      else if (bank_hit(paddr, BANK_SETUP))
        d.prdata = {12'h000, q.setup[widx]};
      else if (bank_hit(paddr, BANK_OFFS))
      begin
        d.prdata = {8'h00, q.offs[widx]};
        d.pslverr = (q.st == CS_RUN);
      end
      else if (bank_hit(paddr, BANK_GAIN))
      begin
        d.prdata = {8'h00, q.gain[widx]};
        d.pslverr = (q.st == CS_RUN);
      end
      else
        d.pslverr = 1'b1;
    end
    // Register writes at the completing edge
    if (fin && pwrite && !q.pslverr)
    begin
      if (paddr == A_STAT && pwdata[ST_REF])
        d.refused = 1'b0;
      if (paddr == A_CTRL)
        d.range2 = pwdata[CT_RANGE];
      if (bank_hit(paddr, BANK_SETUP))
        d.setup[widx] = pwdata[SETUP_W-1:0] & 20'hf7fff;
      if (bank_hit(paddr, BANK_OFFS))
        d.offs[widx] = pwdata[23:0];
      if (bank_hit(paddr, BANK_GAIN))
        d.gain[widx] = pwdata[23:0];
    end
    // Refused request leaves sticky flag, set wins over clear
    if (wr_ctrl && (q.st == CS_IDLE) && is_cal(pwdata[3:0]) && (ch_bad || bad_cfg))
      d.refused = 1'b1;
    case (q.st)
      CS_IDLE:
      begin
        if (go)
        begin
          d.st = CS_RUN;
          d.mode = pwdata[3:0];
          d.ch = wch;
          d.pass = 2'h0;
          d.not_ready_flag = 1'b1;
          d.drdy = 1'b1;
          d.route_fs = (pwdata[3:0] == M_IGAIN);
          d.short_in = (pwdata[3:0] == M_IOFF);
        end
        else if (q.drdy && !cs_low_n)
          d.drdy = 1'b0;
      end
      CS_RUN:
      begin
        if (t_done)
        begin
          if (last)
          begin
            if (q.mode == M_IOFF || q.mode == M_SOFF)
              d.offs[q.ch] = cal_sample;
            else
              d.gain[q.ch] = cal_sample;
            d.not_ready_flag = 1'b0;
            d.drdy = cs_low_n;
            d.st = CS_IDLE;
            d.mode = M_IDLE;
            d.route_fs = 1'b0;
            d.short_in = 1'b0;
          end
          else
            d.pass = q.pass + 2'h1;
        end
      end
      default:
        d.st = CS_IDLE;
    endcase
    d.filt = d.setup[d.ch][SF_FM_LSB +: 4];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= RST_S;
    else
      q <= d;
  end

  // Outputs straight from the state register
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign drdy = q.drdy;
  assign route_fullscale = q.route_fs;
  assign short_pos_neg = q.short_in;
  assign cal_range_double = q.range2;
  assign filter_type_sel = q.filt;
  assign active_chan = q.ch;

  // Checks on sequencer behaviour
  int unsigned dn_cnt;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dn_cnt <= 0;
    else if (go)
      dn_cnt <= 0;
    else if (t_done)
      dn_cnt <= dn_cnt + 1;
  end

  start_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
    go |=> q.not_ready_flag && q.drdy && (q.st == CS_RUN))
    else $error("start did not raise not-ready and data-ready");
  refuse_unity_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ctrl && q.st == CS_IDLE && bad_cfg) |=> q.refused && (q.st == CS_IDLE))
    else $error("unity gain internal calibration was not refused");
  route_fs_a: assert property (@(posedge pclk) disable iff (!presetn)
    (q.st == CS_RUN) |-> (route_fullscale == (q.mode == M_IGAIN)) && !(route_fullscale && short_pos_neg))
    else $error("full-scale routing wrong during calibration");
  short_in_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(short_pos_neg) |-> (q.mode == M_IOFF) ##0 short_pos_neg[*2])
    else $error("input short not held for offset calibration");
  igain_passes_a: assert property (@(posedge pclk) disable iff (!presetn)
    (q.st == CS_RUN && t_done && last && q.mode == M_IGAIN) |-> dn_cnt == 3)
    else $error("internal gain did not take four first conversions");
  one_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
    (q.st == CS_RUN && t_done && q.mode != M_IGAIN) |=> q.st == CS_IDLE)
    else $error("single-pass calibration did not end on first done");
  done_commit_a: assert property (@(posedge pclk) disable iff (!presetn)
    (q.st == CS_RUN && t_done && last && (q.mode == M_SOFF || q.mode == M_IOFF))
    |=> (q.offs[q.ch] == $past(cal_sample)) && !q.not_ready_flag)
    else $error("offset coefficient not committed on completion");
  drdy_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    (q.st == CS_RUN && t_done && last && !cs_low_n) |=> !drdy && (q.st == CS_IDLE))
    else $error("data-ready not low after completion with select low");
  gain_reset_a: assert property (@(posedge pclk)
    $rose(presetn) |-> (q.gain[0] == GAIN_FACTORY))
    else $error("gain coefficient not at factory value after reset");
  filt_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
    (q.st == CS_RUN) |-> filter_type_sel == q.setup[q.ch][SF_FM_LSB +: 4])
    else $error("filter type not taken from channel setup");
  apb_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready) |=> pready)
    else $error("APB access not answered after one wait");
  gain_commit_a: assert property (@(posedge pclk) disable iff (!presetn)
    (q.st == CS_RUN && t_done && last && (q.mode == M_IGAIN || q.mode == M_SGAIN))
    |=> (q.gain[q.ch] == $past(cal_sample)) && !q.not_ready_flag)
    else $error("gain coefficient not committed on completion");
  drdy_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
    (q.st == CS_RUN) |-> drdy)
    else $error("data-ready dropped during calibration");
  busy_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (q.st == CS_RUN && !t_done) |=> (q.st == CS_RUN) && $stable(q.mode) && $stable(q.ch))
    else $error("calibration disturbed while busy");
  pass_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    (q.st == CS_RUN && t_done && !last) |=> (q.st == CS_RUN) && (q.pass == $past(q.pass) + 2'h1))
    else $error("calibration pass not advanced on first-conversion end");
  flag_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(q.not_ready_flag) |-> (q.st == CS_IDLE) && ($past(q.st) == CS_RUN))
    else $error("not-ready cleared outside completion");
  idle_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
    (q.st == CS_IDLE) |-> !q.not_ready_flag && !route_fullscale && !short_pos_neg)
    else $error("idle state shows calibration flags");
  busy_coef_a: assert property (@(posedge pclk) disable iff (!presetn)
    (acc && q.st == CS_RUN && (bank_hit(paddr, BANK_OFFS) || bank_hit(paddr, BANK_GAIN))) |=> pslverr)
    else $error("coefficient access while busy not refused");

  // Main calibration scenarios reached
  igain_cov: cover property (@(posedge pclk) disable iff (!presetn)
    (q.st == CS_RUN && q.mode == M_IGAIN) ##1 (q.st == CS_IDLE));
  soff_cov: cover property (@(posedge pclk) disable iff (!presetn)
    (q.st == CS_RUN && q.mode == M_SOFF) ##1 (q.st == CS_IDLE));
  refuse_cov: cover property (@(posedge pclk) disable iff (!presetn) $rose(q.refused));
  ioff_cov: cover property (@(posedge pclk) disable iff (!presetn)
    (q.st == CS_RUN && q.mode == M_IOFF) ##1 (q.st == CS_IDLE));
  sgain_cov: cover property (@(posedge pclk) disable iff (!presetn)
    (q.st == CS_RUN && q.mode == M_SGAIN) ##1 (q.st == CS_IDLE));
endmodule

// *** bench/adccs_pins.sv ***
// Pin-side model: chip select pin and the filter datapath coefficient.
// Assumes the bench sets the wanted select level and coefficient value.
`timescale 1ns/10ps
module adccs_pins (
  input wire logic pclk,
  input wire logic sel_low,
  input wire logic [23:0] coef,
  output logic cs_n,
  output logic [23:0] cal_sample
);
  // Known levels before the first clock edge
  initial
  begin
    cs_n = 1'b1;
    cal_sample = 24'h000000;
  end

  // Pins follow the wanted levels one cycle later
  always @(posedge pclk)
  begin
    cs_n <= ~sel_low;
    cal_sample <= coef;
  end
endmodule

// *** bench/adc_calibration_sequencer_bench.sv ***
// Self-checking bench for the calibration sequencer, APB master side.
// Assumes adccs_top with a short master-clock prescale and the pin model.
`timescale 1ns/10ps
module adc_calibration_sequencer_bench import adccs_pkg::*; ;
  localparam int DIV = 2;
  localparam int NCH = 8;
  // Per case, repeating: internal gain, internal offset, system offset, system gain
  localparam logic [3:0] TC [0:8] = '{4'h6, 4'h5, 4'h7, 4'h8, 4'h6, 4'h5, 4'h7, 4'h8, 4'h6};
  localparam logic [3:0] TF [0:8] = '{4'h2, 4'h0, 4'h5, 4'h6, 4'h1, 4'h4, 4'h3, 4'h7, 4'h8};
  localparam int TS [0:8] = '{1, 12, 7, 1, 1, 1, 2, 3, 0};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic cs_n;
  logic [23:0] cal_sample;
  logic drdy;
  logic route_fullscale;
  logic short_pos_neg;
  logic cal_range_double;
  logic [3:0] filter_type_sel;
  logic [3:0] active_chan;
  logic sel_low = 1'b1;
  logic [23:0] coef = 24'h0;
  int errors = 0;
  int cmp_count = 0;
  int cyc = 0;

  // Clock and free cycle count
  always #5 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;

  adccs_top #(.NCH(NCH), .MCLK_DIV(DIV)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cs_n(cs_n), .cal_sample(cal_sample), .drdy(drdy), .route_fullscale(route_fullscale),
    .short_pos_neg(short_pos_neg), .cal_range_double(cal_range_double),
    .filter_type_sel(filter_type_sel), .active_chan(active_chan)
  );

  adccs_pins pins (.pclk(pclk), .sel_low(sel_low), .coef(coef), .cs_n(cs_n), .cal_sample(cal_sample));

  // Verdict and end of run
  task summarize;
    if (errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Compare a value
  task chk32(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  // Compare a flag
  task chk1(input logic g, input logic x);
    cmp_count++;
    if (g !== x)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  // Compare a cycle count against a window
  task chkwin(input int g, input int lo, input int hi);
    cmp_count++;
    if (g < lo || g > hi)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, lo);
    end
  endtask

  // One APB transfer, held until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      errors++;
      summarize();
    end
    // Answer taken at the edge that sees pready, then release
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk32(r, x);
  endtask

  // Expected calibration length in pclk cycles
  function automatic int cal_len(input logic [3:0] c, input logic [3:0] fm, input int fs);
    int f;
    int t;
    f = (fs == 0) ? 1 : fs;
    case (fm)
      4'h0: t = FC_SINC4 * ((f > 10) ? 10 : f);
      4'h1: t = FC_SINC4_AVG * ((f > 10) ? 10 : f);
      4'h4: t = FC_SINC3_AVG * f;
      4'h5: t = FC_POST1;
      4'h6: t = FC_POST2;
      4'h7: t = FC_POST3;
      4'h8: t = FC_POST4;
      default: t = FC_SINC3 * f;
    endcase
    return t * DIV * ((c == M_IGAIN) ? 4 : 1);
  endfunction

  function automatic logic [7:0] cadr(input logic [3:0] c, input int ch);
    return 8'(((c == M_IOFF || c == M_SOFF) ? 128 : 192) + 4 * ch);
  endfunction

  // Main sequence
  initial
  begin
    logic [31:0] r;
    logic e;
    int ch;
    int t0;
    int n;
    logic [23:0] smp;
    void'($urandom(27391));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h40, {12'h0, SETUP_RST});
    rd(8'(8'hc0 + 4 * (NCH - 1)), {8'h0, GAIN_FACTORY});
    rd(8'h80, {8'h0, OFFS_RST});
    apb(1'b0, 8'h08, 32'h0, r, e);
    chk1(e, 1'b1);
    apb(1'b0, 8'(8'h40 + 4 * NCH), 32'h0, r, e);
    chk1(e, 1'b1);
    wr(A_CTRL, 32'h100);
    @(negedge pclk);
    chk1(cal_range_double, 1'b1);
    wr(A_CTRL, 32'h4);
    rd(A_STAT, 32'h0);
    @(negedge pclk);
    chk1(cal_range_double, 1'b0);
    chk1(drdy, 1'b0);
    wr(8'h40, 32'h12);
    wr(A_CTRL, 32'h6);
    rd(A_STAT, 32'h2);
    wr(A_STAT, 32'h2);
    rd(A_STAT, 32'h0);
    for (int i = 0; i < 9; i++)
    begin
      if (TC[i] == M_IGAIN)
        ch = $urandom % NCH;
      smp = 24'($urandom);
      coef <= smp;
      wr(8'(8'h40 + 4 * ch), 32'(TF[i]) | 32'(TS[i] << 4) | ((TC[i] == M_IGAIN) ? 32'h20000 : 32'h0));
      if (TC[i] == M_IGAIN)
        wr(8'(8'h80 + 4 * ch), {8'h0, OFFS_RST});
      wr(A_CTRL, 32'(TC[i]) | 32'(ch << 4));
      t0 = cyc;
      @(posedge pclk);
      @(negedge pclk);
      chk1(route_fullscale, TC[i] == M_IGAIN);
      chk1(short_pos_neg, TC[i] == M_IOFF);
      chk1(drdy, 1'b1);
      chk32(32'(filter_type_sel), 32'(TF[i]));
      chk32(32'(active_chan), 32'(ch));
      rd(A_STAT, 32'h5);
      apb(1'b0, cadr(TC[i], ch), 32'h0, r, e);
      chk1(e, 1'b1);
      n = 0;
      while (drdy !== 1'b0 && n < 60000)
      begin
        @(negedge pclk);
        n++;
      end
      if (drdy !== 1'b0)
      begin
        errors++;
        summarize();
      end
      chkwin(cyc - t0, cal_len(TC[i], TF[i], TS[i]) - 2, cal_len(TC[i], TF[i], TS[i]) + 6);
      rd(cadr(TC[i], ch), {8'h0, smp});
      rd(A_STAT, 32'h0);
    end
    sel_low <= 1'b0;
    wr(8'h40, 32'h12);
    wr(A_CTRL, 32'h5);
    n = 0;
    do
    begin
      apb(1'b0, A_STAT, 32'h0, r, e);
      n++;
    end
    while (r[ST_BUSY] !== 1'b0 && n < 200);
    chk1(r[ST_BUSY], 1'b0);
    @(negedge pclk);
    chk1(drdy, 1'b1);
    sel_low <= 1'b1;
    repeat (6) @(posedge pclk);
    @(negedge pclk);
    chk1(drdy, 1'b0);
    summarize();
  end
endmodule
